// ==== dmt_top.sv ====
`timescale 1ns/100ps
`include "dmt_params.svh"

module dmt_top #(
  parameter int ADDR_W = 8
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              standby,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic [2:0]        awprot,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic [2:0]        arprot,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  output logic [`DMT_NCH-1:0]    match_irq,
  output logic                   irq
);

  localparam int NCH = `DMT_NCH;

  // ****************************************
  // State
  // ****************************************
  logic                  awready_reg, awready_next;
  logic                  wready_reg, wready_next;
  logic                  bvalid_reg, bvalid_next;
  logic [1:0]            bresp_reg, bresp_next;
  logic                  arready_reg, arready_next;
  logic                  rvalid_reg, rvalid_next;
  logic [31:0]           rdata_reg, rdata_next;
  logic [1:0]            rresp_reg, rresp_next;
  logic                  aw_full_reg, aw_full_next;
  logic                  w_full_reg, w_full_next;
  logic [ADDR_W-1:0]     waddr_reg, waddr_next;
  logic [31:0]           wdat_reg, wdat_next;
  logic [3:0]            wstb_reg, wstb_next;
  logic [NCH-1:0]        run_reg, run_next;
  dmt_pkg::dmt_csr_t     csr_reg [NCH];
  dmt_pkg::dmt_csr_t     csr_next [NCH];
  logic [NCH-1:0]        arm_reg, arm_next;
  logic [NCH-1:0]        istat_reg, istat_next;
  logic [NCH-1:0]        imask_reg, imask_next;
  logic [NCH-1:0]        mirq_reg, mirq_next;
  logic                  irq_reg, irq_next;
  logic [`DMT_PRE_W-1:0] pre_reg, pre_next;
  logic                  stby_s1_reg, stby_s2_reg;

  logic [`DMT_NTAP-1:0]  taps;
  logic [NCH-1:0]        tick, match, cnt_we, per_we;
  logic [`DMT_CW-1:0]    cnt [NCH];
  logic [`DMT_CW-1:0]    per [NCH];
  logic                  do_wr;
  logic [4:0]            wdec, rdec;
  dmt_pkg::dmt_wr_t      wr;
  logic [31:0]           rword;

  // Hit bit above a register index
  function automatic logic [4:0] dmt_decode(input logic [ADDR_W-1:0] a);
    logic [3:0] idx;
    logic       ok;
    idx = a[5:2];
    ok  = (a[1:0] == 2'b00) && (a[ADDR_W-1:6] == '0) && (idx <= `DMT_IDX_IMASK);
    return {ok, idx};
  endfunction : dmt_decode

  function automatic logic [3:0] dmt_ch_idx(input logic [3:0] base, input int ch);
    return base + 4'(ch) * `DMT_IDX_STRIDE;
  endfunction : dmt_ch_idx

  // ****************************************
  // Prescaler taps
  // ****************************************
  assign pre_next = pre_reg + 1'b1;

  genvar k;
  generate
    for (k = 0; k < `DMT_NTAP; k++) begin : g_tap
      assign taps[k] = &pre_reg[`DMT_DIV_BASE + `DMT_DIV_STEP * k - 1:0]; // RULE_04
    end
  endgenerate

  // ****************************************
  // Channels
  // ****************************************
  assign wdec     = dmt_decode(waddr_reg);
  assign rdec     = dmt_decode(araddr);
  assign wr.data  = wdat_reg[15:0];
  assign wr.be    = wstb_reg[1:0]; // RULE_13

  genvar c;
  generate
    for (c = 0; c < NCH; c++) begin : g_ch
      assign tick[c]   = taps[csr_reg[c].prescale_sel]; // RULE_05
      assign cnt_we[c] = do_wr && wdec[4] && wdec[3:0] == dmt_ch_idx(`DMT_IDX_CNT0, c);
      assign per_we[c] = do_wr && wdec[4] && wdec[3:0] == dmt_ch_idx(`DMT_IDX_PER0, c);
      dmt_chan u_chan (
        .aclk    (aclk),
        .aresetn (aresetn),
        .clr     (stby_s2_reg),
        .run     (run_reg[c]), // RULE_02
        .tick    (tick[c]),
        .cnt_we  (cnt_we[c]),
        .per_we  (per_we[c]),
        .wr      (wr),
        .cnt     (cnt[c]),
        .per     (per[c]),
        .match   (match[c]) // RULE_01
      );
    end
  endgenerate

  // ****************************************
  // Read data mux
  // ****************************************
  always_comb begin
    rword = 32'h0000_0000; // RULE_10
    if (rdec[3:0] == `DMT_IDX_RUN) rword[NCH-1:0] = run_reg;
    if (rdec[3:0] == `DMT_IDX_ISTAT) rword[NCH-1:0] = istat_reg;
    if (rdec[3:0] == `DMT_IDX_IMASK) rword[NCH-1:0] = imask_reg;
    for (int i = 0; i < NCH; i++) begin
      if (rdec[3:0] == dmt_ch_idx(`DMT_IDX_CSR0, i)) begin
        rword[`DMT_BIT_FLAG]                   = csr_reg[i].match_flag; // RULE_06
        rword[`DMT_BIT_IE]                     = csr_reg[i].match_irq_enable;
        rword[`DMT_BIT_SEL_HI:`DMT_BIT_SEL_LO] = csr_reg[i].prescale_sel;
      end
      if (rdec[3:0] == dmt_ch_idx(`DMT_IDX_CNT0, i)) rword[`DMT_CW-1:0] = cnt[i];
      if (rdec[3:0] == dmt_ch_idx(`DMT_IDX_PER0, i)) rword[`DMT_CW-1:0] = per[i];
    end
    if (!rdec[4]) rword = 32'h0000_0000;
  end

  // ****************************************
  // Bus and register next state
  // ****************************************
  always_comb begin
    awready_next = awready_reg;
    wready_next  = wready_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    arready_next = arready_reg;
    rvalid_next  = rvalid_reg;
    rdata_next   = rdata_reg;
    rresp_next   = rresp_reg;
    aw_full_next = aw_full_reg;
    w_full_next  = w_full_reg;
    waddr_next   = waddr_reg;
    wdat_next    = wdat_reg;
    wstb_next    = wstb_reg;
    run_next     = run_reg;
    arm_next     = arm_reg;
    istat_next   = istat_reg;
    imask_next   = imask_reg;
    do_wr        = 1'b0;
    for (int i = 0; i < NCH; i++) csr_next[i] = csr_reg[i];

    if (awready_reg && awvalid) begin
      aw_full_next = 1'b1;
      waddr_next   = awaddr;
      awready_next = 1'b0;
    end
    if (wready_reg && wvalid) begin
      w_full_next = 1'b1;
      wdat_next   = wdata;
      wstb_next   = wstrb;
      wready_next = 1'b0;
    end
    if (aw_full_reg && w_full_reg && !bvalid_reg) begin
      do_wr        = 1'b1;
      aw_full_next = 1'b0;
      w_full_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = wdec[4] ? `DMT_RESP_OK : `DMT_RESP_ERR;
    end
    if (bvalid_reg && bready) begin
      bvalid_next  = 1'b0;
      awready_next = 1'b1;
      wready_next  = 1'b1;
    end

    if (do_wr && wdec[4] && wstb_reg[0]) begin
      if (wdec[3:0] == `DMT_IDX_RUN) run_next = wdat_reg[NCH-1:0]; // RULE_02
      if (wdec[3:0] == `DMT_IDX_IMASK) imask_next = wdat_reg[NCH-1:0];
      if (wdec[3:0] == `DMT_IDX_ISTAT) istat_next = istat_reg & ~wdat_reg[NCH-1:0];
      for (int i = 0; i < NCH; i++) begin
        if (wdec[3:0] == dmt_ch_idx(`DMT_IDX_CSR0, i)) begin
          csr_next[i].match_irq_enable = wdat_reg[`DMT_BIT_IE]; // RULE_08
          csr_next[i].prescale_sel = wdat_reg[`DMT_BIT_SEL_HI:`DMT_BIT_SEL_LO]; // RULE_04
          if (!wdat_reg[`DMT_BIT_FLAG] && arm_reg[i])
            csr_next[i].match_flag = 1'b0; // RULE_07
          arm_next[i] = 1'b0;
        end
      end
    end

    if (rvalid_reg && rready) begin
      rvalid_next  = 1'b0;
      arready_next = 1'b1;
    end
    if (arready_reg && arvalid) begin
      arready_next = 1'b0;
      rvalid_next  = 1'b1;
      rdata_next   = rword;
      rresp_next   = rdec[4] ? `DMT_RESP_OK : `DMT_RESP_ERR;
      for (int i = 0; i < NCH; i++)
        if (rdec[4] && rdec[3:0] == dmt_ch_idx(`DMT_IDX_CSR0, i) && csr_reg[i].match_flag)
          arm_next[i] = 1'b1; // RULE_07
    end

    // Hardware set wins over software clears; the standby clear below wins over it
    for (int i = 0; i < NCH; i++) begin
      if (match[i]) begin
        csr_next[i].match_flag = 1'b1; // RULE_14
        istat_next[i] = 1'b1;
      end
    end

    if (stby_s2_reg) begin
      run_next = '0; // RULE_11
      arm_next = '0;
      for (int i = 0; i < NCH; i++) csr_next[i] = '0; // RULE_11
    end

    for (int i = 0; i < NCH; i++)
      mirq_next[i] = csr_next[i].match_flag && csr_next[i].match_irq_enable; // RULE_15
    irq_next = |(istat_next & imask_next);
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `DMT_RESP_OK;
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= `DMT_RESP_OK;
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      waddr_reg   <= '0;
      wdat_reg    <= 32'h0000_0000;
      wstb_reg    <= 4'h0;
      run_reg     <= '0; // RULE_11
      arm_reg     <= '0;
      istat_reg   <= '0;
      imask_reg   <= '0;
      mirq_reg    <= '0;
      irq_reg     <= 1'b0;
      pre_reg     <= '0;
      stby_s1_reg <= 1'b0;
      stby_s2_reg <= 1'b0;
      for (int i = 0; i < NCH; i++) csr_reg[i] <= '0; // RULE_11
    end else begin
      awready_reg <= awready_next;
      wready_reg  <= wready_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
      aw_full_reg <= aw_full_next;
      w_full_reg  <= w_full_next;
      waddr_reg   <= waddr_next;
      wdat_reg    <= wdat_next;
      wstb_reg    <= wstb_next;
      run_reg     <= run_next;
      arm_reg     <= arm_next;
      istat_reg   <= istat_next;
      imask_reg   <= imask_next;
      mirq_reg    <= mirq_next; // RULE_09
      irq_reg     <= irq_next;
      pre_reg     <= pre_next;
      stby_s1_reg <= standby;
      stby_s2_reg <= stby_s1_reg;
      for (int i = 0; i < NCH; i++) csr_reg[i] <= csr_next[i];
    end
  end

  assign awready   = awready_reg;
  assign wready    = wready_reg;
  assign bvalid    = bvalid_reg;
  assign bresp     = bresp_reg;
  assign arready   = arready_reg;
  assign rvalid    = rvalid_reg;
  assign rdata     = rdata_reg;
  assign rresp     = rresp_reg;
  assign match_irq = mirq_reg;
  assign irq       = irq_reg;

  // ****************************************
  // Checks
  // ****************************************
  flag_set_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_06
    match[0] && !stby_s2_reg |=> csr_reg[0].match_flag) else $error("flag not set");
  flag_hold_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_07
    csr_reg[1].match_flag && !arm_reg[1] && !stby_s2_reg |=> csr_reg[1].match_flag)
    else $error("flag cleared without read");
  irq_line_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_15
    ##1 match_irq[0] == (csr_reg[0].match_irq_enable && csr_reg[0].match_flag))
    else $error("irq output mismatch");
  rsvd_zero_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_10
    rvalid_reg |-> rdata_reg[31:16] == 16'h0000) else $error("reserved bits set");
  div8_tick_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_04
    taps[0] |=> !taps[0] [*7] ##1 taps[0]) else $error("divide by 8 wrong");
  stby_clr_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_11
    stby_s2_reg |=> run_reg == '0 && csr_reg[0] == '0) else $error("standby no clear");
  bresp_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    bvalid_reg && !bready |=> bvalid_reg && $stable(bresp_reg)) else $error("b dropped");
  rsp_time_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_13
    arready_reg && arvalid |=> rvalid_reg) else $error("read answer late");

  irq_seen_c: cover property (@(posedge aclk) disable iff (!aresetn) irq_reg);
  flag_clr_c: cover property (@(posedge aclk) disable iff (!aresetn)
    csr_reg[0].match_flag ##1 !csr_reg[0].match_flag);
  both_run_c: cover property (@(posedge aclk) disable iff (!aresetn) &run_reg);

endmodule : dmt_top

// ==== dmt_params.svh ====
// Overview of operation
// RULE_01 - Two independent 16-bit interval counters
// RULE_02 - Run bit 1 counts, 0 holds
// RULE_03 - Running counter increments on each prescaled tick
// RULE_04 - Select 00..11 picks divide 8/32/128/512
// RULE_05 - Each channel picks its own prescale rate
// RULE_06 - Bit 7 flag reads 1 after match
// RULE_07 - Flag clears by zero write after reading one
// RULE_08 - Bit 6 enables channel interrupt, reset off
// RULE_09 - Each channel requests its own interrupt
// RULE_10 - Reserved bits read zero, write zero
// RULE_11 - Run and control registers zero on reset/standby
// RULE_12 - Counters reset zero, periods reset all ones
// RULE_13 - Byte, halfword and word accesses accepted
// RULE_14 - Match clears counter, sets flag, continues
// RULE_15 - Interrupt while flag and enable both set
// RULE_16 - Match clear beats a counter write
// RULE_17 - Counter write beats a coinciding increment
`ifndef DMT_PARAMS_SVH
`define DMT_PARAMS_SVH

`define DMT_CW          16
`define DMT_NCH         2
`define DMT_OFF_BASE    32'hffff83d0
`define DMT_OFF_RUN     32'hffff83d0
`define DMT_OFF_CSR0    32'hffff83d2
`define DMT_OFF_CNT0    32'hffff83d4
`define DMT_OFF_PER0    32'hffff83d6
`define DMT_OFF_CSR1    32'hffff83d8
`define DMT_OFF_CNT1    32'hffff83da
`define DMT_OFF_PER1    32'hffff83dc
`define DMT_IDX(o)      4'((((o) - `DMT_OFF_BASE) >> 1))
`define DMT_IDX_RUN     `DMT_IDX(`DMT_OFF_RUN)
`define DMT_IDX_CSR0    `DMT_IDX(`DMT_OFF_CSR0)
`define DMT_IDX_CNT0    `DMT_IDX(`DMT_OFF_CNT0)
`define DMT_IDX_PER0    `DMT_IDX(`DMT_OFF_PER0)
`define DMT_IDX_STRIDE  4'h3
`define DMT_IDX_ISTAT   4'h7
`define DMT_IDX_IMASK   4'h8
`define DMT_BIT_FLAG    7
`define DMT_BIT_IE      6
`define DMT_BIT_SEL_HI  1
`define DMT_BIT_SEL_LO  0
`define DMT_RST_CNT     16'h0000
`define DMT_RST_PER     16'hffff
`define DMT_PRE_W       9
`define DMT_DIV_BASE    3
`define DMT_DIV_STEP    2
`define DMT_NTAP        4
`define DMT_RESP_OK     2'b00
`define DMT_RESP_ERR    2'b10

`endif

// ==== dmt_pkg.sv ====
package dmt_pkg;

  typedef struct packed {
    logic       match_flag;
    logic       match_irq_enable;
    logic [1:0] prescale_sel;
  } dmt_csr_t;

  typedef struct packed {
    logic [15:0] data;
    logic [1:0]  be;
  } dmt_wr_t;

endpackage : dmt_pkg

// ==== dmt_chan.sv ====
`timescale 1ns/100ps
`include "dmt_params.svh"

module dmt_chan (
  input  wire logic            aclk,
  input  wire logic            aresetn,
  input  wire logic            clr,
  input  wire logic            run,
  input  wire logic            tick,
  input  wire logic            cnt_we,
  input  wire logic            per_we,
  input  wire dmt_pkg::dmt_wr_t wr,
  output logic [`DMT_CW-1:0]   cnt,
  output logic [`DMT_CW-1:0]   per,
  output logic                 match
);

  logic [`DMT_CW-1:0] cnt_reg;
  logic [`DMT_CW-1:0] cnt_next;
  logic [`DMT_CW-1:0] per_reg;
  logic [`DMT_CW-1:0] per_next;
  logic               match_reg;
  logic               match_next;
  logic               hit;

  function automatic logic [`DMT_CW-1:0] dmt_merge(input logic [`DMT_CW-1:0] old,
                                                   input dmt_pkg::dmt_wr_t w);
    logic [`DMT_CW-1:0] r;
    r = old;
    if (w.be[0]) r[7:0] = w.data[7:0];
    if (w.be[1]) r[15:8] = w.data[15:8];
    return r;
  endfunction : dmt_merge

  assign hit = run && tick && (cnt_reg == per_reg); // RULE_14

  always_comb begin
    cnt_next   = cnt_reg;
    per_next   = per_reg;
    match_next = 1'b0;
    if (clr) begin
      cnt_next = `DMT_RST_CNT; // RULE_12
      per_next = `DMT_RST_PER; // RULE_12
    end else begin
      if (hit) begin
        cnt_next   = `DMT_RST_CNT; // RULE_16
        match_next = 1'b1; // RULE_14
      end else if (cnt_we) begin
        cnt_next = dmt_merge(cnt_reg, wr); // RULE_17
      end else if (run && tick) begin
        cnt_next = cnt_reg + 1'b1; // RULE_03
      end
      if (per_we) per_next = dmt_merge(per_reg, wr);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg   <= `DMT_RST_CNT;
      per_reg   <= `DMT_RST_PER;
      match_reg <= 1'b0;
    end else begin
      cnt_reg   <= cnt_next;
      per_reg   <= per_next;
      match_reg <= match_next;
    end
  end

  assign cnt   = cnt_reg;
  assign per   = per_reg;
  assign match = match_reg;

  // ****************************************
  // Checks
  // ****************************************
  run_hold_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_02
    !run && !cnt_we && !clr |=> $stable(cnt_reg)) else $error("halted counter moved");
  count_tick_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_03
    run && tick && !cnt_we && !clr && !hit |=> cnt_reg == $past(cnt_reg) + 1'b1)
    else $error("counter missed tick");
  match_clear_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_14
    hit && !clr |=> cnt_reg == `DMT_RST_CNT && match_reg) else $error("match not cleared");
  match_prio_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_16
    hit && cnt_we && !clr |=> cnt_reg == `DMT_RST_CNT) else $error("write beat match");
  write_prio_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_17
    cnt_we && wr.be == 2'b11 && !hit && !clr |=> cnt_reg == $past(wr.data))
    else $error("increment beat write");
  reset_val_a: assert property (@(posedge aclk) // RULE_12
    !aresetn |=> cnt_reg == `DMT_RST_CNT && per_reg == `DMT_RST_PER)
    else $error("bad reset values");
  match_seen_c: cover property (@(posedge aclk) disable iff (!aresetn) hit);
  match_write_c: cover property (@(posedge aclk) disable iff (!aresetn) hit && cnt_we);

endmodule : dmt_chan

// ==== dmt_top_tb.sv ====
`timescale 1ns/100ps
module dmt_top_tb;
  // Byte address = 4 * register index
  localparam logic [7:0] A_RUN = 8'h00, A_CSR0 = 8'h04, A_CNT0 = 8'h08, A_PER0 = 8'h0c;
  localparam logic [7:0] A_CSR1 = 8'h10, A_CNT1 = 8'h14, A_PER1 = 8'h18;
  localparam logic [7:0] A_ISTAT = 8'h1c, A_IMASK = 8'h20;
  logic        aclk, aresetn, standby, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d, d0;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, match_irq, r;
  int          errors, n_compared, s, div;

  dmt_top u_dut (.aclk(aclk), .aresetn(aresetn), .standby(standby), .awaddr(awaddr),
    .awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .match_irq(match_irq), .irq(irq));

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  // ****************************************
  // Report and checks
  // ****************************************
  task finish_test;
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test

  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task chk_rng(input string name, input int lo, input int hi, input logic [31:0] got);
    n_compared++;
    if (((got >= lo) && (got <= hi)) !== 1'b1) begin
      errors++;
      $display("ERROR %s expected %0d..%0d seen %h", name, lo, hi, got);
    end
  endtask : chk_rng

  task hang(input string name);
    errors++;
    $display("ERROR %s expected handshake seen timeout", name);
    finish_test();
  endtask : hang

  // ****************************************
  // Bus tasks
  // ****************************************
  task axi_wr(input logic [7:0] a, input logic [31:0] dv, input logic [3:0] st,
              output logic [1:0] resp);
    logic aw_done;
    logic w_done;
    int   k;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= dv;
    wstrb <= st;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 200; k++) begin
      @(posedge aclk);
      if (!aw_done && awready === 1'b1) begin
        awvalid <= 1'b0;
        aw_done = 1'b1;
      end
      if (!w_done && wready === 1'b1) begin
        wvalid <= 1'b0;
        w_done = 1'b1;
      end
      if (bvalid === 1'b1) break;
    end
    if (k == 200) hang("write");
    resp = bresp;
    bready <= 1'b0;
  endtask : axi_wr

  task rd(input logic [7:0] a, output logic [31:0] dv, output logic [1:0] resp);
    logic ar_done;
    int   k;
    ar_done = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 200; k++) begin
      @(posedge aclk);
      if (!ar_done && arready === 1'b1) begin
        arvalid <= 1'b0;
        ar_done = 1'b1;
      end
      if (rvalid === 1'b1) break;
    end
    if (k == 200) hang("read");
    dv = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : rd

  task wr(input logic [7:0] a, input logic [31:0] dv);
    axi_wr(a, dv, 4'h3, r);
    chk("bresp", 32'h0, {30'h0, r});
  endtask : wr

  task rdc(input string name, input logic [7:0] a, input logic [31:0] exp);
    rd(a, d, r);
    chk(name, exp, d);
  endtask : rdc

  task wait_irq(input int ch);
    int k;
    for (k = 0; k < 2000; k++) begin
      @(posedge aclk);
      if (match_irq[ch] === 1'b1) break;
    end
    if (k == 2000) hang("match_irq");
  endtask : wait_irq

  task chk_rst;
    rdc("run", A_RUN, 32'h0);
    rdc("csr0", A_CSR0, 32'h0);
    rdc("csr1", A_CSR1, 32'h0);
    rdc("cnt0", A_CNT0, 32'h0);
    rdc("cnt1", A_CNT1, 32'h0);
    rdc("per0", A_PER0, 32'hffff);
    rdc("per1", A_PER1, 32'hffff);
  endtask : chk_rst

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    errors = 0;
    n_compared = 0;
    aresetn = 1'b0;
    standby = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    awaddr = 8'h0;
    araddr = 8'h0;
    wdata = 32'h0;
    wstrb = 4'h0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    chk_rst();
    // Reserved bits, flag write of one, lane without byte 0
    axi_wr(A_RUN, 32'hffff, 4'h3, r);
    rdc("run rsv", A_RUN, 32'h3);
    axi_wr(A_RUN, 32'h0, 4'h2, r);
    rdc("run lane", A_RUN, 32'h3);
    wr(A_RUN, 32'h0);
    axi_wr(A_CSR1, 32'hffff, 4'h3, r);
    rdc("csr1 rsv", A_CSR1, 32'h43);
    wr(A_CSR1, 32'h0);
    // Byte and word lanes
    wr(A_CNT0, 32'h1234);
    axi_wr(A_CNT0, 32'h0000ab00, 4'h2, r);
    rdc("cnt0 byte", A_CNT0, 32'hab34);
    axi_wr(A_PER0, 32'h000000cd, 4'h1, r);
    rdc("per0 byte", A_PER0, 32'hffcd);
    axi_wr(A_PER0, 32'hdead0005, 4'hf, r);
    rdc("per0 word", A_PER0, 32'h0005);
    wr(A_PER0, 32'hffff);
    // Prescale rates, channel 1 fixed at divide by 8
    for (s = 0; s < 4; s++) begin
      div = 8 << (2 * s);
      wr(A_CNT0, 32'h0);
      wr(A_CNT1, 32'h0);
      wr(A_CSR0, s);
      wr(A_CSR1, 32'h0);
      wr(A_RUN, 32'h3);
      repeat (16 * div) @(posedge aclk);
      wr(A_RUN, 32'h0);
      rd(A_CNT0, d0, r);
      chk_rng("cnt0 rate", 15, 17, d0);
      rd(A_CNT1, d, r);
      chk_rng("cnt1 rate", 2 * div - 1, 2 * div + 1, d);
      repeat (40) @(posedge aclk);
      rdc("cnt0 held", A_CNT0, d0);
    end
    // Match on channel 0 with interrupt enabled
    wr(A_CNT0, 32'h0);
    wr(A_PER0, 32'h3);
    wr(A_CSR0, 32'h40);
    wr(A_RUN, 32'h1);
    wait_irq(0);
    wr(A_RUN, 32'h0);
    chk("irq0", 32'h1, {31'h0, match_irq[0]});
    rdc("cnt0 clr", A_CNT0, 32'h0);
    rdc("istat", A_ISTAT, 32'h1);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(A_IMASK, 32'h1);
    repeat (2) @(posedge aclk);
    chk("irq on", 32'h1, {31'h0, irq});
    wr(A_ISTAT, 32'h1);
    repeat (2) @(posedge aclk);
    chk("irq clr", 32'h0, {31'h0, irq});
    // Flag clear only by zero after a read of one
    rdc("csr0 flag", A_CSR0, 32'hc0);
    wr(A_CSR0, 32'hc0);
    wr(A_CSR0, 32'h40);
    rdc("csr0 kept", A_CSR0, 32'hc0);
    wr(A_CSR0, 32'h40);
    rdc("csr0 clr", A_CSR0, 32'h40);
    repeat (2) @(posedge aclk);
    chk("irq0 off", 32'h0, {31'h0, match_irq[0]});
    // Counter writes on running ticks, five-cycle spacing walks every tick phase
    wr(A_PER0, 32'h5);
    wr(A_CSR0, 32'h0);
    wr(A_RUN, 32'h1);
    for (s = 0; s < 16; s++) begin
      wr(A_CNT0, (s < 8) ? 32'h5 : 32'h2);
      @(posedge aclk);
    end
    wr(A_RUN, 32'h0);
    rdc("csr0 match", A_CSR0, 32'h80);
    // Channel 1 alone
    wr(A_CNT1, 32'h0);
    wr(A_PER1, 32'h2);
    wr(A_CSR1, 32'h41);
    wr(A_RUN, 32'h2);
    wait_irq(1);
    wr(A_RUN, 32'h0);
    chk("irq pair", 32'h2, {30'h0, match_irq});
    wr(A_CSR1, 32'h01);
    repeat (2) @(posedge aclk);
    chk("irq1 off", 32'h0, {31'h0, match_irq[1]});
    rdc("csr1 flag", A_CSR1, 32'h81);
    // Unmapped places
    rd(8'h24, d, r);
    chk("rresp", 32'h2, {30'h0, r});
    chk("rdata", 32'h0, d);
    rd(8'h02, d, r);
    chk("rresp mis", 32'h2, {30'h0, r});
    axi_wr(8'h24, 32'h1, 4'h3, r);
    chk("bresp", 32'h2, {30'h0, r});
    // Standby entry
    wr(A_RUN, 32'h3);
    wr(A_CSR0, 32'h43);
    wr(A_CNT1, 32'h7);
    wr(A_PER1, 32'h5);
    @(posedge aclk);
    standby <= 1'b1;
    repeat (4) @(posedge aclk);
    standby <= 1'b0;
    repeat (4) @(posedge aclk);
    chk_rst();
    finish_test();
  end
endmodule : dmt_top_tb
